// [verilog/e1af_pkg.sv]
// Package with the register map, field positions and timing constants of the E1 receive event flag block.
`default_nettype none
package e1af_pkg;
	// ==================================================
	// Register indices (byte address is four times the index)
	localparam logic [11:0] IDX_CODE_STATUS = 12'hb0a;
	localparam logic [11:0] IDX_CODE_IRQ_ENABLE = 12'hb0b;
	localparam logic [11:0] IDX_NAT_STATUS = 12'hb0c;
	localparam logic [11:0] IDX_NAT_IRQ_ENABLE = 12'hb0d;
	localparam logic [11:0] IDX_CONTROL = 12'hb0e;
	localparam int ADDR_W = 16;

	// ==================================================
	// Field positions
	localparam int BIT_ALT_STATE = 7;
	localparam int BIT_ALT_CHANGE = 6;
	localparam int BIT_IW_STATE = 5;
	localparam int BIT_IW_CHANGE = 4;
	localparam int BIT_NAT_1111 = 7;
	localparam int BIT_NAT_1110 = 6;
	localparam int BIT_ANNEX_B = 0;

	// ==================================================
	// Writable masks and reset values
	localparam logic [7:0] CODE_EN_MASK = 8'h50;
	localparam logic [7:0] CODE_FLAG_MASK = 8'h50;
	localparam logic [7:0] NAT_MASK = 8'hc0;
	localparam logic [7:0] CTRL_MASK = 8'h01;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ==================================================
	// Pattern codes
	localparam logic [5:0] ALT_PATTERN_A = 6'h2a;
	localparam logic [5:0] ALT_PATTERN_B = 6'h15;
	localparam logic [3:0] NAT6_ALL_ONES = 4'hf;
	localparam logic [3:0] NAT6_THREE_ONES_ZERO = 4'he;

	// ==================================================
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int IW_TIMEOUT_MS = 400;
	localparam longint IW_TIMEOUT_CYCLES_L = longint'(IW_TIMEOUT_MS) * longint'(CLK_HZ) / 64'd1000;
	localparam int IW_TIMEOUT_CYCLES = int'(IW_TIMEOUT_CYCLES_L);
	localparam int IW_CNT_W = 24;

	// ==================================================
	// Receive conditions tracked for change detection
	typedef struct packed {
		logic alt_det;
		logic interworking;
		logic nat6_1111;
		logic nat6_1110;
	} e1af_cond_t;

	typedef enum logic [1:0] {
		E1AF_BUS_IDLE = 2'b00,
		E1AF_BUS_WAIT = 2'b01,
		E1AF_BUS_DONE = 2'b11
	} e1af_bus_state_t;
endpackage
`default_nettype wire

// [verilog/e1af_top.sv]
// Receive E1 event flags, enables, interrupt and APB register slave.
`default_nettype none
// Operation
// - Enable register bit 6 gates the alternating-pattern change interrupt.
// - Alternating-pattern change flag sets on start and on stop of detection.
// - Enable register bit 4, reset 0, gates the interworking change interrupt.
// - Interworking change flag sets on entry to and return from interworking.
// - Interrupt output only for change events whose enable bit is set.
// - National status bit 7 sets when debounced Sa6 starts or stops being 1111.
// - National status bit 6 sets when debounced Sa6 starts or stops being 1110.
// - National flags clear on read or write of their register.
// - Alternating pattern is the repeating sequence 101010 on received bits.
// - With annex B on, interworking declared after 400 ms of basic frame alignment without multiframe alignment.
module e1af_top #(
	parameter int IW_TIMEOUT = e1af_pkg::IW_TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [e1af_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive framer conditions
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	input wire logic rx_frame_aligned,
	input wire logic rx_crc_mf_aligned,
	input wire logic [3:0] rx_nat6_debounced,
	// Interrupt
	output logic irq
);
	// ==================================================
	// State
	e1af_pkg::e1af_bus_state_t bus_reg, bus_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [7:0] code_en_reg, code_en_next;
	logic [7:0] code_flag_reg, code_flag_next;
	logic [7:0] nat_flag_reg, nat_flag_next;
	logic [7:0] nat_en_reg, nat_en_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [5:0] shift_reg, shift_next;
	logic [2:0] fill_reg, fill_next;
	logic [e1af_pkg::IW_CNT_W-1:0] iw_cnt_reg, iw_cnt_next;
	e1af_pkg::e1af_cond_t cond_reg, cond_next;
	logic irq_reg, irq_next;

	// ==================================================
	// Bus decode
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic [11:0] idx;
	logic hit;
	logic [7:0] rd_byte;

	assign access_done = psel && penable && pready_reg;
	assign wr_done = access_done && pwrite;
	assign rd_done = access_done && !pwrite;
	assign idx = paddr[13:2];

	always_comb begin
		hit = 1'b1;
		rd_byte = e1af_pkg::RESET_BYTE;
		case (idx)
			e1af_pkg::IDX_CODE_STATUS: begin
				rd_byte = code_flag_reg;
				rd_byte[e1af_pkg::BIT_ALT_STATE] = cond_reg.alt_det;
				rd_byte[e1af_pkg::BIT_IW_STATE] = cond_reg.interworking;
			end
			e1af_pkg::IDX_CODE_IRQ_ENABLE: begin
				rd_byte = code_en_reg & e1af_pkg::CODE_EN_MASK;
			end
			e1af_pkg::IDX_NAT_STATUS: begin
				rd_byte = nat_flag_reg;
			end
			e1af_pkg::IDX_NAT_IRQ_ENABLE: begin
				rd_byte = nat_en_reg;
			end
			e1af_pkg::IDX_CONTROL: begin
				rd_byte = ctrl_reg;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		if (paddr[e1af_pkg::ADDR_W-1:14] != '0 || paddr[1:0] != 2'b00) begin
			hit = 1'b0;
			rd_byte = e1af_pkg::RESET_BYTE;
		end
	end

	// ==================================================
	// APB handshake: the answer is registered in WAIT and pready stands in DONE.
	// Every access therefore sees two wait states before its completing edge.
	always_comb begin
		bus_next = bus_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		case (bus_reg)
			e1af_pkg::E1AF_BUS_IDLE: begin
				if (psel && penable) begin
					bus_next = e1af_pkg::E1AF_BUS_WAIT;
				end
			end
			e1af_pkg::E1AF_BUS_WAIT: begin
				pready_next = 1'b1;
				pslverr_next = !hit;
				prdata_next = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				bus_next = e1af_pkg::E1AF_BUS_DONE;
			end
			e1af_pkg::E1AF_BUS_DONE: begin
				bus_next = e1af_pkg::E1AF_BUS_IDLE;
			end
			default: begin
				bus_next = e1af_pkg::E1AF_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_reg <= e1af_pkg::E1AF_BUS_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			bus_reg <= bus_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// ==================================================
	// Status clear strobe
	// Flags clear at the edge that loads prdata, not at the completing edge.
	// An event landing between those two edges would otherwise be cleared unseen.
	logic clr_strobe;
	logic clr_code;
	logic clr_nat;

	assign clr_strobe = (bus_reg == e1af_pkg::E1AF_BUS_WAIT) && psel && penable && hit;
	assign clr_code = clr_strobe && (idx == e1af_pkg::IDX_CODE_STATUS);
	assign clr_nat = clr_strobe && (idx == e1af_pkg::IDX_NAT_STATUS);

	// ==================================================
	// Receive condition tracking
	logic alt_match;
	logic iw_expired;
	logic iw_window;

	// The fill count keeps a part-filled shift register from matching after reset.
	always_comb begin
		shift_next = shift_reg;
		fill_next = fill_reg;
		if (rx_bit_valid) begin
			shift_next = {shift_reg[4:0], rx_bit};
			if (fill_reg != 3'd6) begin
				fill_next = fill_reg + 3'd1;
			end
		end
	end

	// The pattern holds while the last six bits alternate, in either phase.
	assign alt_match = (fill_reg == 3'd6) &&
		(shift_reg == e1af_pkg::ALT_PATTERN_A || shift_reg == e1af_pkg::ALT_PATTERN_B);

	// The timer runs only while basic alignment holds and multiframe alignment is missing.
	assign iw_window = ctrl_reg[e1af_pkg::BIT_ANNEX_B] && rx_frame_aligned && !rx_crc_mf_aligned;
	assign iw_expired = (iw_cnt_reg >= IW_TIMEOUT[e1af_pkg::IW_CNT_W-1:0] - 1'b1);

	always_comb begin
		iw_cnt_next = iw_cnt_reg;
		cond_next = cond_reg;
		cond_next.alt_det = alt_match;
		cond_next.nat6_1111 = (rx_nat6_debounced == e1af_pkg::NAT6_ALL_ONES);
		cond_next.nat6_1110 = (rx_nat6_debounced == e1af_pkg::NAT6_THREE_ONES_ZERO);
		if (!iw_window) begin
			iw_cnt_next = '0;
		end else if (!iw_expired) begin
			iw_cnt_next = iw_cnt_reg + 1'b1;
		end
		if (!ctrl_reg[e1af_pkg::BIT_ANNEX_B] || rx_crc_mf_aligned) begin
			cond_next.interworking = 1'b0;
		end else if (iw_window && iw_expired) begin
			cond_next.interworking = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= 6'h00;
			fill_reg <= 3'h0;
			iw_cnt_reg <= '0;
			cond_reg <= '0;
		end else begin
			shift_reg <= shift_next;
			fill_reg <= fill_next;
			iw_cnt_reg <= iw_cnt_next;
			cond_reg <= cond_next;
		end
	end

	// ==================================================
	// Change events, sticky flags and registers
	logic alt_change;
	logic iw_change;
	logic n1111_change;
	logic n1110_change;
	logic [7:0] code_set;
	logic [7:0] code_clr;
	logic [7:0] nat_set;
	logic nat_clr;

	// Comparing next with registered conditions sets a flag and irq on one edge.
	assign alt_change = cond_next.alt_det != cond_reg.alt_det;
	assign iw_change = cond_next.interworking != cond_reg.interworking;
	assign n1111_change = cond_next.nat6_1111 != cond_reg.nat6_1111;
	assign n1110_change = cond_next.nat6_1110 != cond_reg.nat6_1110;

	always_comb begin
		code_set = 8'h00;
		code_set[e1af_pkg::BIT_ALT_CHANGE] = alt_change;
		code_set[e1af_pkg::BIT_IW_CHANGE] = iw_change;
		nat_set = 8'h00;
		nat_set[e1af_pkg::BIT_NAT_1111] = n1111_change;
		nat_set[e1af_pkg::BIT_NAT_1110] = n1110_change;
		code_clr = 8'h00;
		if (clr_code) begin
			code_clr = pwrite ? pwdata[7:0] : 8'hff;
		end
		nat_clr = clr_nat;
	end

	always_comb begin
		code_en_next = code_en_reg;
		nat_en_next = nat_en_reg;
		ctrl_next = ctrl_reg;
		if (wr_done && hit) begin
			case (idx)
				e1af_pkg::IDX_CODE_IRQ_ENABLE: begin
					code_en_next = pwdata[7:0] & e1af_pkg::CODE_EN_MASK;
				end
				e1af_pkg::IDX_NAT_IRQ_ENABLE: begin
					nat_en_next = pwdata[7:0] & e1af_pkg::NAT_MASK;
				end
				e1af_pkg::IDX_CONTROL: begin
					ctrl_next = pwdata[7:0] & e1af_pkg::CTRL_MASK;
				end
				default: begin
					ctrl_next = ctrl_reg;
				end
			endcase
		end
		// A change in the clearing cycle still sets its flag.
		// Masking on every update keeps the reserved bits at zero.
		code_flag_next = ((code_flag_reg & ~code_clr) | code_set) & e1af_pkg::CODE_FLAG_MASK;
		nat_flag_next = ((nat_clr ? 8'h00 : nat_flag_reg) | nat_set) & e1af_pkg::NAT_MASK;
		irq_next = |(code_flag_next & code_en_next) | |(nat_flag_next & nat_en_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_en_reg <= e1af_pkg::RESET_BYTE;
			nat_en_reg <= e1af_pkg::RESET_BYTE;
			ctrl_reg <= e1af_pkg::RESET_BYTE;
			code_flag_reg <= e1af_pkg::RESET_BYTE;
			nat_flag_reg <= e1af_pkg::RESET_BYTE;
			irq_reg <= 1'b0;
		end else begin
			code_en_reg <= code_en_next;
			nat_en_reg <= nat_en_next;
			ctrl_reg <= ctrl_next;
			code_flag_reg <= code_flag_next;
			nat_flag_reg <= nat_flag_next;
			irq_reg <= irq_next;
		end
	end

	// ==================================================
	// Outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
endmodule
`default_nettype wire

// [tb/e1af_props.sv]
// Port-level checker of the E1 receive event flag block.
`default_nettype none
module e1af_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [e1af_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Receive code and interrupt
	input wire logic [3:0] rx_nat6_debounced,
	input wire logic irq
);
	// ====
	// Shadow of the enables and national flags.
	logic [7:0] en_q, en_next, nen_q, nen_next;
	logic [1:0] nat_q, nat_next, c_q, c_next;
	logic pe_q, done, cap;
	assign done = psel && penable && pready;
	assign cap = psel && penable && pe_q && !pready;
	always_comb begin
		c_next = {rx_nat6_debounced == 4'hf, rx_nat6_debounced == 4'he};
		nat_next = (cap && paddr == 16'h2c30) ? 2'b00 : nat_q;
		nat_next = nat_next | (c_next ^ c_q);
		en_next = (done && pwrite && paddr == 16'h2c2c) ? (pwdata[7:0] & 8'h50) : en_q;
		nen_next = (done && pwrite && paddr == 16'h2c34) ? (pwdata[7:0] & 8'hc0) : nen_q;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en_q, nen_q, nat_q, c_q, pe_q} <= '0;
		end else begin
			{en_q, nen_q, nat_q, c_q, pe_q} <= {en_next, nen_next, nat_next, c_next, psel && penable};
		end
	end
	// ====
	// Properties.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd(a);
		done && !pwrite && paddr == a;
	endsequence
	sequence s_cap(a);
		cap && !pwrite && paddr == a;
	endsequence
	property p_two_wait; psel && $rose(penable) |-> !pready ##1 !pready ##1 pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
	property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
	property p_en_read; s_rd(16'h2c2c) |-> prdata == {24'h0, en_q}; endproperty
	property p_nat_read; s_cap(16'h2c30) |=> prdata == {24'h0, $past(nat_q), 6'h0}; endproperty
	property p_quiet_irq; en_q == 8'h00 && !(|(nat_q & nen_q[7:6])) |-> !irq; endproperty
	property p_nat_irq; |(nat_q & nen_q[7:6]) && $past(|(nat_q & nen_q[7:6])) |-> irq; endproperty
	a_two_wait: assert property (p_two_wait) else $error("wait states wrong");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	a_err_zero: assert property (p_err_zero) else $error("error response with data");
	a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
	a_en_read: assert property (p_en_read) else $error("enable readback wrong");
	a_nat_read: assert property (p_nat_read) else $error("national flags wrong");
	a_quiet_irq: assert property (p_quiet_irq) else $error("irq without an enabled flag");
	a_nat_irq: assert property (p_nat_irq) else $error("enabled flag without irq");
endmodule
bind e1af_top e1af_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .rx_nat6_debounced, .irq);
`default_nettype wire

// [tb/e1_rx_alarm_event_flags_tb.sv]
// Self-checking testbench of the E1 receive event flag block.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module e1_rx_alarm_event_flags_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IW = 20;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_bit = 0, rx_bit_valid = 0;
	logic rx_frame_aligned = 0, rx_crc_mf_aligned = 0, pready, pslverr, irq, ev;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv, exp_v;
	logic [3:0] rx_nat6_debounced = '0, m_prev = '0;
	logic [7:0] m_en = '0, m_nen = '0, m_code = '0, m_nat = '0;
	logic [15:0] addrs [5] = '{16'h2c28, 16'h2c2c, 16'h2c30, 16'h2c34, 16'h2c38};
	logic [3:0] codes [5] = '{4'hf, 4'he, 4'he, 4'h0, 4'hf};
	int n_fail = 0, n_compared = 0, cyc = 0;
	e1af_top #(.IW_TIMEOUT(IW)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rx_bit, .rx_bit_valid, .rx_frame_aligned, .rx_crc_mf_aligned, .rx_nat6_debounced, .irq);
	initial forever #20 pclk = ~pclk;
	// ====
	// Bus and stimulus tasks with the reference model.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [15:0] a);
		apb(1'b0, a, 32'h0);
		case (a)
			16'h2c28: exp_v = {24'h0, m_code};
			16'h2c2c: exp_v = {24'h0, m_en};
			16'h2c30: exp_v = {24'h0, m_nat};
			16'h2c34: exp_v = {24'h0, m_nen};
			default: exp_v = 32'h0;
		endcase
		if (a == 16'h2c28) m_code &= 8'hb0;
		if (a == 16'h2c30) m_nat = 8'h0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, a, {8'($urandom), 16'h0, d});
		if (a == 16'h2c2c) m_en = d & 8'h50;
		if (a == 16'h2c34) m_nen = d & 8'hc0;
		if (a == 16'h2c30) m_nat = 8'h0;
	endtask
	task automatic nat(input logic [3:0] c);
		if ((c == 4'hf) != (m_prev == 4'hf)) m_nat |= 8'h80;
		if ((c == 4'he) != (m_prev == 4'he)) m_nat |= 8'h40;
		m_prev = c;
		rx_nat6_debounced <= c;
		repeat (2) @(posedge pclk);
	endtask
	task automatic bits(input logic [7:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_bit <= b[i];
			rx_bit_valid <= 1'b1;
			@(posedge pclk);
		end
		rx_bit_valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic exp_irq();
		return (|(m_nat & m_nen)) || (|(m_code & m_en));
	endfunction
	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	// ====
	// Scenarios.
	initial begin
		void'($urandom(32'hb43c));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (addrs[i]) begin
			rd(addrs[i]);
			`CHK(rv, 32'h0)
		end
		wr(16'h2c2d, 8'hff);
		`CHK(ev, 1'b1)
		rd(16'h2c3c);
		`CHK({ev, rv}, 33'h100000000)
		rd(16'h2c2c);
		`CHK(rv, 32'h0)
		repeat (4) begin
			wr(16'h2c2c, 8'($urandom));
			rd(16'h2c2c);
			`CHK(rv, exp_v)
		end
		wr(16'h2c34, 8'hc0);
		foreach (codes[i]) begin
			nat(codes[i]);
			`CHK(irq, exp_irq())
			rd(16'h2c30);
			`CHK(rv, exp_v)
		end
		nat(4'he);
		wr(16'h2c30, 8'($urandom));
		rd(16'h2c30);
		`CHK(rv, exp_v)
		wr(16'h2c2c, 8'h00);
		bits(8'h2a, 6);
		m_code |= 8'hc0;
		`CHK(irq, exp_irq())
		rd(16'h2c28);
		`CHK(rv, exp_v)
		wr(16'h2c2c, 8'h40);
		bits(8'h03, 2);
		m_code = (m_code & 8'h7f) | 8'h40;
		`CHK(irq, exp_irq())
		rd(16'h2c28);
		`CHK(rv, exp_v)
		wr(16'h2c2c, 8'h10);
		rx_frame_aligned <= 1'b1;
		wr(16'h2c38, 8'h01);
		repeat (IW + 5) @(posedge pclk);
		m_code |= 8'h30;
		`CHK(irq, exp_irq())
		rd(16'h2c28);
		`CHK(rv, exp_v)
		rx_crc_mf_aligned <= 1'b1;
		repeat (3) @(posedge pclk);
		m_code = (m_code & 8'hdf) | 8'h10;
		`CHK(irq, exp_irq())
		rd(16'h2c28);
		`CHK(rv, exp_v)
		close_out();
	end
endmodule
`default_nettype wire
